// File: mis_led_model.sv
// Purpose: lights and exposure input, counting active clocks
// Assumes: sampled on the system clock
// Notes:   unknown strobe counts as active
`default_nettype none
module mis_led_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_clr,
  input  wire logic       i_exp,
  input  wire logic       i_stb,
  input  wire logic       i_pol_neg,
  input  wire logic [3:0] i_led,
  output var  int         o_exp_n,
  output var  int         o_stb_n,
  output var  int         o_led_n [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_clk_sys) begin
    if (i_clr) begin
      o_exp_n <= 0;
      o_stb_n <= 0;
      o_led_n <= '{0, 0, 0, 0};
    end else begin
      o_exp_n <= o_exp_n + int'(i_exp === 1'b1);
      o_stb_n <= o_stb_n + int'(i_stb !== i_pol_neg);
      for (int l = 0; l < 4; l++) o_led_n[l] <= o_led_n[l] + int'(i_led[l] === 1'b1);
    end
  end
endmodule : mis_led_model
`default_nettype wire

// File: mis_pkg.sv
// Purpose: shared constants for the interval strobe sequencer
// Assumes: 50 MHz system clock, 15 ns sequencer tick
// Notes:   config field codes select one word of an interval entry
`default_nettype none

package mis_pkg;

  localparam int unsigned CLK_FREQ_HZ   = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int unsigned TICK_NS       = 15;

  localparam int unsigned NUM_INTERVALS = 16;
  localparam int unsigned NUM_PWM       = 4;
  localparam int unsigned NUM_LINES     = 4;
  localparam int unsigned TICK_W        = 32;
  localparam int unsigned ACC_W         = 8;

  localparam logic [3:0] FLD_DURATION  = 4'h0;
  localparam logic [3:0] FLD_EXP_START = 4'h1;
  localparam logic [3:0] FLD_EXP_STOP  = 4'h2;
  localparam logic [3:0] FLD_STB_START = 4'h3;
  localparam logic [3:0] FLD_STB_STOP  = 4'h4;
  localparam logic [3:0] FLD_PWM_PER   = 4'h5;
  localparam logic [3:0] FLD_PWM_ON0   = 4'h6;

  localparam logic [31:0] RST_TICKS    = 32'h0000_0000;

  typedef enum logic {
    MIS_ST_IDLE,
    MIS_ST_RUN
  } mis_state_t;

endpackage : mis_pkg

`default_nettype wire

// File: mis_pwm_chan.sv
// Purpose: one pwm channel, on while the shared phase is below on-time
// Assumes: phase wraps at the interval's period, both in ticks
// Notes:   on-time equal to the period gives a steady on level
`default_nettype none

module mis_pwm_chan #(
  parameter int unsigned TICK_W = mis_pkg::TICK_W
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset,
  input  wire logic              i_run,
  input  wire logic [TICK_W-1:0] i_phase,
  input  wire logic [TICK_W-1:0] i_on_time,
  output logic                   o_pwm
);

  logic pwm_r;

  // full swing only: duty is on-time over period
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= i_run && (i_phase < i_on_time); // RL8 RL16
    end
  end

  assign o_pwm = pwm_r;

endmodule : mis_pwm_chan

`default_nettype wire

// File: mis_sequencer.sv
// Purpose: trigger-started sequencer of programmed timing intervals
// Assumes: config ports driven by local logic on i_clk_sys
// Notes:   i_trigger is a pin and is synchronised before use
//
// Overview of operation
// RL1 - all times count 15 ns ticks
// RL2 - each interval lasts its own duration
// RL3 - exposure pulse starts at its delay
// RL4 - exposure pulse stops at interval-relative value
// RL5 - strobe pulse starts at its delay
// RL6 - strobe pulse stops at interval-relative value
// RL7 - per-interval pwm period for all channels
// RL8 - pwm outputs switch fully on or off
// RL9 - trigger runs all programmed intervals in order
// RL10 - up to sixteen independent intervals
// RL11 - software keeps exposure inside interval
// RL12 - full setting set readable for persistent storage
// RL13 - each pwm channel routable to output line
// RL14 - pulse A to exposure, pulse B strobe
// RL15 - strobe polarity selectable
// RL16 - duty equals on-time over period, per interval
// RL17 - after last interval, outputs off, idle
`default_nettype none

module mis_sequencer #(
  parameter int unsigned N_INT  = mis_pkg::NUM_INTERVALS,
  parameter int unsigned N_PWM  = mis_pkg::NUM_PWM,
  parameter int unsigned N_LINE = mis_pkg::NUM_LINES,
  parameter int unsigned TICK_W = mis_pkg::TICK_W,
  parameter int unsigned IDX_W  = $clog2(N_INT),
  parameter int unsigned CH_W   = $clog2(N_PWM)
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic                   i_trigger,
  input  wire logic [IDX_W:0]         i_interval_count,
  input  wire logic                   i_cfg_we,
  input  wire logic [IDX_W-1:0]       i_interval_index_select,
  input  wire logic [3:0]             i_cfg_field,
  input  wire logic [TICK_W-1:0]      i_cfg_wdata,
  output logic      [TICK_W-1:0]      o_cfg_rdata,
  input  wire logic                   i_exp_src_sel,
  input  wire logic                   i_strobe_src_sel,
  input  wire logic                   i_strobe_pol_neg,
  input  wire logic [N_LINE-1:0]      i_line_en,
  input  wire logic [N_LINE*CH_W-1:0] i_line_src,
  input  wire logic                   i_overrun_clr,
  output logic                        o_exposure_trig,
  output logic                        o_strobe,
  output logic      [N_LINE-1:0]      o_out_line,
  output logic                        o_busy,
  output logic      [IDX_W-1:0]       o_interval_index,
  output logic                        o_seq_done,
  output logic                        o_trig_overrun
);

  localparam int unsigned ACC_W = mis_pkg::ACC_W;

  // interval table
  logic [TICK_W-1:0] dur_mem     [N_INT];
  logic [TICK_W-1:0] exp_on_mem  [N_INT];
  logic [TICK_W-1:0] exp_off_mem [N_INT];
  logic [TICK_W-1:0] stb_on_mem  [N_INT];
  logic [TICK_W-1:0] stb_off_mem [N_INT];
  logic [TICK_W-1:0] per_mem     [N_INT];
  logic [TICK_W-1:0] pwm_on_mem  [N_INT][N_PWM];

  logic [TICK_W-1:0] cfg_rdata_r;
  logic [TICK_W-1:0] rd_val;
  logic [3:0]        wr_ch;

  logic [ACC_W-1:0]  acc_r;
  logic [ACC_W-1:0]  tick_sum;
  logic [ACC_W-1:0]  tick_step;

  logic              trig_s1_r;
  logic              trig_s2_r;
  logic              trig_s3_r;
  logic              trig_rise;

  mis_pkg::mis_state_t state_r;
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  last_idx;
  logic [TICK_W-1:0] elapsed_r;
  logic [TICK_W:0]   elapsed_adv;
  logic              int_end;
  logic              running;

  logic [TICK_W-1:0] pwm_ph_r;
  logic [TICK_W:0]   ph_adv;

  logic              pulse_a;
  logic              pulse_b;
  logic              exp_r;
  logic              strobe_r;
  logic [N_PWM-1:0]  pwm_out;
  logic [N_LINE-1:0] line_r;
  logic              done_r;
  logic              overrun_r;

  // configuration writes take effect on the next clock, even in the interval now running
  assign wr_ch = 4'(i_cfg_field - mis_pkg::FLD_PWM_ON0);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < N_INT; i++) begin
        dur_mem[i]     <= mis_pkg::RST_TICKS[TICK_W-1:0];
        exp_on_mem[i]  <= mis_pkg::RST_TICKS[TICK_W-1:0];
        exp_off_mem[i] <= mis_pkg::RST_TICKS[TICK_W-1:0];
        stb_on_mem[i]  <= mis_pkg::RST_TICKS[TICK_W-1:0];
        stb_off_mem[i] <= mis_pkg::RST_TICKS[TICK_W-1:0];
        per_mem[i]     <= mis_pkg::RST_TICKS[TICK_W-1:0];
        for (int c = 0; c < N_PWM; c++) begin
          pwm_on_mem[i][c] <= mis_pkg::RST_TICKS[TICK_W-1:0];
        end
      end
    end else if (i_cfg_we) begin // RL10
      case (i_cfg_field)
        mis_pkg::FLD_DURATION:  dur_mem[i_interval_index_select]     <= i_cfg_wdata;
        mis_pkg::FLD_EXP_START: exp_on_mem[i_interval_index_select]  <= i_cfg_wdata;
        mis_pkg::FLD_EXP_STOP:  exp_off_mem[i_interval_index_select] <= i_cfg_wdata;
        mis_pkg::FLD_STB_START: stb_on_mem[i_interval_index_select]  <= i_cfg_wdata;
        mis_pkg::FLD_STB_STOP:  stb_off_mem[i_interval_index_select] <= i_cfg_wdata;
        mis_pkg::FLD_PWM_PER:   per_mem[i_interval_index_select]     <= i_cfg_wdata;
        default: begin
          if (i_cfg_field >= mis_pkg::FLD_PWM_ON0 && wr_ch < 4'(N_PWM)) begin
            pwm_on_mem[i_interval_index_select][wr_ch[CH_W-1:0]] <= i_cfg_wdata; // RL16
          end
        end
      endcase
    end
  end

  // readback so the whole table can be saved and restored
  always_comb begin
    rd_val = '0;
    case (i_cfg_field)
      mis_pkg::FLD_DURATION:  rd_val = dur_mem[i_interval_index_select];
      mis_pkg::FLD_EXP_START: rd_val = exp_on_mem[i_interval_index_select];
      mis_pkg::FLD_EXP_STOP:  rd_val = exp_off_mem[i_interval_index_select];
      mis_pkg::FLD_STB_START: rd_val = stb_on_mem[i_interval_index_select];
      mis_pkg::FLD_STB_STOP:  rd_val = stb_off_mem[i_interval_index_select];
      mis_pkg::FLD_PWM_PER:   rd_val = per_mem[i_interval_index_select];
      default: begin
        if (i_cfg_field >= mis_pkg::FLD_PWM_ON0 && wr_ch < 4'(N_PWM)) begin
          rd_val = pwm_on_mem[i_interval_index_select][wr_ch[CH_W-1:0]];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cfg_rdata_r <= '0;
    end else begin
      cfg_rdata_r <= rd_val; // RL12
    end
  end

  // 15 ns ticks from a 20 ns clock: one or two ticks per clock edge
  assign tick_sum  = acc_r + ACC_W'(mis_pkg::CLK_PERIOD_NS);
  assign tick_step = ACC_W'(tick_sum / ACC_W'(mis_pkg::TICK_NS)); // RL1

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      acc_r <= '0;
    end else begin
      acc_r <= ACC_W'(tick_sum % ACC_W'(mis_pkg::TICK_NS)); // RL1
    end
  end

  // trigger pin synchroniser, edge taken after the second stage
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      trig_s1_r <= i_trigger;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  assign trig_rise = trig_s2_r & ~trig_s3_r;

  // a count of zero runs one interval
  assign last_idx = (i_interval_count == '0) ? '0 :
                    IDX_W'(i_interval_count - 1'b1);

  assign running     = (state_r == mis_pkg::MIS_ST_RUN);
  assign elapsed_adv = {1'b0, elapsed_r} + (TICK_W + 1)'(tick_step);
  assign int_end     = elapsed_adv >= {1'b0, dur_mem[idx_r]}; // RL2

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_r   <= mis_pkg::MIS_ST_IDLE;
      idx_r     <= '0;
      elapsed_r <= '0;
    end else begin
      unique case (state_r)
        mis_pkg::MIS_ST_IDLE: begin
          if (trig_rise) begin
            state_r   <= mis_pkg::MIS_ST_RUN; // RL9
            idx_r     <= '0;
            elapsed_r <= '0;
          end
        end
        mis_pkg::MIS_ST_RUN: begin
          if (int_end) begin
            elapsed_r <= '0;
            if (idx_r == last_idx) begin
              state_r <= mis_pkg::MIS_ST_IDLE; // RL17
              idx_r   <= '0;
            end else begin
              idx_r <= idx_r + 1'b1; // RL9
            end
          end else begin
            elapsed_r <= elapsed_adv[TICK_W-1:0]; // RL2
          end
        end
      endcase
    end
  end

  // shared pwm phase, restarted with each interval
  assign ph_adv = {1'b0, pwm_ph_r} + (TICK_W + 1)'(tick_step);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pwm_ph_r <= '0;
    end else if (!running || int_end) begin
      pwm_ph_r <= '0;
    end else if (per_mem[idx_r] == '0) begin
      pwm_ph_r <= '0;
    end else if (ph_adv >= {1'b0, per_mem[idx_r]}) begin
      pwm_ph_r <= TICK_W'(ph_adv - {1'b0, per_mem[idx_r]}); // RL7
    end else begin
      pwm_ph_r <= ph_adv[TICK_W-1:0];
    end
  end

  // both pulses measured from the start of the interval
  assign pulse_a = running &&
                   (elapsed_r >= exp_on_mem[idx_r]) && // RL3
                   (elapsed_r <  exp_off_mem[idx_r]);  // RL4
  assign pulse_b = running &&
                   (elapsed_r >= stb_on_mem[idx_r]) && // RL5
                   (elapsed_r <  stb_off_mem[idx_r]);  // RL6

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      exp_r <= 1'b0;
    end else begin
      exp_r <= i_exp_src_sel ? pulse_b : pulse_a; // RL14
    end
  end

  // idle strobe level follows the selected polarity
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= (i_strobe_src_sel ? pulse_a : pulse_b) ^ i_strobe_pol_neg; // RL14 RL15
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_PWM; g++) begin : g_pwm
      mis_pwm_chan #(
        .TICK_W (TICK_W)
      ) u_chan (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_run     (running && !int_end),
        .i_phase   (pwm_ph_r),
        .i_on_time (pwm_on_mem[idx_r][g]),
        .o_pwm     (pwm_out[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      line_r <= '0;
    end else begin
      for (int l = 0; l < N_LINE; l++) begin
        line_r[l] <= i_line_en[l] & pwm_out[i_line_src[l*CH_W +: CH_W]]; // RL13
      end
    end
  end

  // end-of-sequence pulse
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= running && int_end && (idx_r == last_idx); // RL17
    end
  end

  // trigger while running is ignored but flagged; a new one beats the clear
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      overrun_r <= 1'b0;
    end else if (running && trig_rise) begin
      overrun_r <= 1'b1;
    end else if (i_overrun_clr) begin
      overrun_r <= 1'b0;
    end
  end

  assign o_cfg_rdata      = cfg_rdata_r;
  assign o_exposure_trig  = exp_r;
  assign o_strobe         = strobe_r;
  assign o_out_line       = line_r;
  assign o_busy           = running;
  assign o_interval_index = idx_r;
  assign o_seq_done       = done_r;
  assign o_trig_overrun   = overrun_r;

endmodule : mis_sequencer

`default_nettype wire

// File: mis_sequencer_checker.sv
// Purpose: port checker for the interval strobe sequencer
// Assumes: one clock domain, async active-high reset
// Notes:   bound to mis_sequencer below
`default_nettype none
module mis_sequencer_checker #(
  parameter int unsigned N_LINE = 4,
  parameter int unsigned IDX_W  = 4
) (
  input wire logic              i_clk_sys,
  input wire logic              i_reset,
  input wire logic              i_trigger,
  input wire logic [IDX_W:0]    i_interval_count,
  input wire logic [3:0]        i_cfg_field,
  input wire logic [31:0]       o_cfg_rdata,
  input wire logic              i_strobe_pol_neg,
  input wire logic [N_LINE-1:0] i_line_en,
  input wire logic              o_exposure_trig,
  input wire logic              o_strobe,
  input wire logic [N_LINE-1:0] o_out_line,
  input wire logic              o_busy,
  input wire logic [IDX_W-1:0]  o_interval_index,
  input wire logic              o_seq_done,
  input wire logic              o_trig_overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_idle_quiet: assert property (!o_busy [*3] |-> !o_exposure_trig && o_out_line == '0
    && o_strobe == $past(i_strobe_pol_neg)) else $error("output active while idle");
  a_trig_start: assert property (!o_busy && !o_seq_done && $rose(i_trigger)
    |-> ##[3:4] o_busy) else $error("trigger did not start");
  a_trig_ignored: assert property (o_busy && $rose(i_trigger) |-> ##[1:5] o_trig_overrun)
    else $error("busy trigger not flagged");
  a_done_pulse: assert property ($fell(o_busy) |-> o_seq_done ##1 !o_seq_done)
    else $error("bad done pulse");
  a_index_step: assert property (o_busy && $past(o_busy) && $changed(o_interval_index)
    |-> o_interval_index == $past(o_interval_index) + 4'h1) else $error("index skipped");
  a_first_index: assert property ($rose(o_busy) |-> o_interval_index == '0)
    else $error("run not at interval 0");
  a_index_range: assert property (o_busy && i_interval_count != '0
    |-> o_interval_index < i_interval_count) else $error("index beyond count");
  a_exp_in_run: assert property (o_exposure_trig |-> o_busy || $past(o_busy))
    else $error("exposure outside run");
  a_line_gated: assert property ($stable(i_line_en) |-> (o_out_line & ~i_line_en) == '0)
    else $error("disabled line active");
  a_unmapped_zero: assert property ($past(i_cfg_field) > 4'h9 |-> o_cfg_rdata == '0)
    else $error("unmapped field not zero");
  c_done: cover property (o_seq_done);
  c_overrun: cover property ($rose(o_trig_overrun));
  c_strobe_on: cover property (o_busy && o_strobe != i_strobe_pol_neg);
endmodule : mis_sequencer_checker
bind mis_sequencer mis_sequencer_checker #(.N_LINE(N_LINE), .IDX_W(IDX_W)) i_chk (
  .i_clk_sys, .i_reset, .i_trigger, .i_interval_count, .i_cfg_field, .o_cfg_rdata,
  .i_strobe_pol_neg, .i_line_en, .o_exposure_trig, .o_strobe, .o_out_line, .o_busy,
  .o_interval_index, .o_seq_done, .o_trig_overrun);
`default_nettype wire

// File: mis_sequencer_tb.sv
// Purpose: self-checking bench for the interval strobe sequencer
// Assumes: durations and delays in multiples of 4 ticks
// Notes:   4 ticks take exactly 3 clocks whatever the tick phase
`default_nettype none
module mis_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_reset = 1, i_trigger = 0, i_cfg_we = 0, i_overrun_clr = 0, m_clr = 0;
  logic i_exp_src_sel = 0, i_strobe_src_sel = 0, i_strobe_pol_neg = 0;
  logic [4:0] i_interval_count = '0;
  logic [3:0] i_interval_index_select = '0, i_cfg_field = '0, i_line_en = 4'h7;
  logic [31:0] i_cfg_wdata = '0, o_cfg_rdata;
  logic [7:0] i_line_src = 8'h24;
  logic [3:0] o_out_line, o_interval_index;
  logic o_exposure_trig, o_strobe, o_busy, o_seq_done, o_trig_overrun;
  int exp_n, stb_n, led_n[4], icnt[16], dur_c[16], bad_count = 0, tests_run = 0, done_n = 0;
  int eb[4] = '{6, 11, 5, 0}, ec[4] = '{5, 11, 5, 11};
  mis_sequencer i_dut (.i_clk_sys, .i_reset, .i_trigger, .i_interval_count, .i_cfg_we,
    .i_interval_index_select, .i_cfg_field, .i_cfg_wdata, .o_cfg_rdata, .i_exp_src_sel,
    .i_strobe_src_sel, .i_strobe_pol_neg, .i_line_en, .i_line_src, .i_overrun_clr,
    .o_exposure_trig, .o_strobe, .o_out_line, .o_busy, .o_interval_index, .o_seq_done,
    .o_trig_overrun);
  mis_led_model i_led (.i_clk_sys, .i_clr(m_clr), .i_exp(o_exposure_trig), .i_stb(o_strobe),
    .i_pol_neg(i_strobe_pol_neg), .i_led(o_out_line), .o_exp_n(exp_n), .o_stb_n(stb_n),
    .o_led_n(led_n));
  initial forever #10 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) if (o_busy === 1'b1) icnt[o_interval_index]++;
  always @(negedge i_clk_sys) if (o_seq_done === 1'b1) done_n++;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input int idx, input int f, input int d);
    @(posedge i_clk_sys);
    i_cfg_we <= 1'b1;
    i_interval_index_select <= 4'(idx);
    i_cfg_field <= 4'(f);
    i_cfg_wdata <= 32'(d);
    @(posedge i_clk_sys);
    i_cfg_we <= 1'b0;
  endtask : wr
  task automatic rd(input int idx, input int f, input int exp);
    @(posedge i_clk_sys);
    i_interval_index_select <= 4'(idx);
    i_cfg_field <= 4'(f);
    @(posedge i_clk_sys);
    #1 check("cfg_rdata", o_cfg_rdata, 32'(exp));
  endtask : rd
  task automatic prog(input int idx, input int v[10]);
    for (int f = 0; f < 10; f++) wr(idx, f, v[f]);
    dur_c[idx] = 3 * v[0] / 4;
  endtask : prog
  task automatic run(input int n, input logic ov);
    foreach (icnt[k]) icnt[k] = 0;
    done_n = 0;
    @(posedge i_clk_sys);
    i_interval_count <= 5'(n);
    i_trigger <= 1'b1;
    m_clr <= 1'b1;
    @(posedge i_clk_sys);
    i_trigger <= 1'b0;
    m_clr <= 1'b0;
    for (int t = 0; t < 8 && o_busy !== 1'b1; t++) @(negedge i_clk_sys);
    if (ov) begin
      @(posedge i_clk_sys);
      i_trigger <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      #1 check("overrun", o_trig_overrun, 1);
      @(posedge i_clk_sys);
      i_trigger <= 1'b0;
      i_overrun_clr <= 1'b1;
      @(posedge i_clk_sys);
      i_overrun_clr <= 1'b0;
    end
    for (int t = 0; t < 3000 && o_busy !== 1'b0; t++) @(negedge i_clk_sys);
    repeat (4) @(posedge i_clk_sys);
    #1 check("overrun", o_trig_overrun, 0);
    check("seq_done", done_n, 1);
    for (int k = 0; k < n; k++) check("interval_clocks", icnt[k], dur_c[k]);
  endtask : run
  task automatic final_report;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int i = 0; i < 16; i++) prog(i, '{4, 0, 4, 4, 4, 0, 0, 0, 0, 0});
    run(16, 1'b1);
    check("exposure_clocks", exp_n, 48);
    check("strobe_clocks", stb_n, 0);
    prog(0, '{16, 0, 8, 4, 12, 8, 4, 8, 0, 0});
    prog(1, '{8, 4, 8, 0, 4, 4, 0, 0, 4, 0});
    prog(2, '{4, 0, 4, 4, 8, 0, 0, 0, 0, 0});
    run(3, 1'b0);
    check("exposure_clocks", exp_n, 12);
    check("strobe_clocks", stb_n, 9);
    foreach (eb[l]) check("line_clocks", led_n[l], eb[l]);
    @(posedge i_clk_sys);
    i_exp_src_sel <= 1'b1;
    i_strobe_src_sel <= 1'b1;
    i_strobe_pol_neg <= 1'b1;
    i_line_en <= 4'hf;
    i_line_src <= 8'h66;
    run(3, 1'b0);
    check("exposure_clocks", exp_n, 9);
    check("strobe_clocks", stb_n, 12);
    foreach (ec[l]) check("line_clocks", led_n[l], ec[l]);
    run(0, 1'b0);
    check("single_interval", icnt[0], 12);
    check("single_interval", icnt[1], 0);
    check("exposure_clocks", exp_n, 6);
    rd(0, mis_pkg::FLD_PWM_PER, 8);
    rd(1, mis_pkg::FLD_EXP_STOP, 8);
    wr(1, 10, 32'h1234_5678);
    rd(1, 10, 0);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    final_report();
  end
endmodule : mis_sequencer_tb
`default_nettype wire
